/* File: core/pgc_path.v */
// Parallel data path of one channel pair: DDR capture, coding, serial out.
`timescale 1ns/1ps
`include "pgc_consts.vh"
module pgc_path (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        ce,
    input  wire        coding_select,
    input  wire        coding_enable_reg_bit,
    input  wire        violation_display_enable,
    input  wire        nibble_mode,
    input  wire        transmit_clock,
    input  wire [9:0]  transmit_bus_bits,
    input  wire [19:0] rx_word,
    input  wire [1:0]  rx_word_valid,
    output wire [3:0]  ser_bits,
    output wire [1:0]  ser_valid,
    output wire [1:0]  tx_overrun,
    output wire        coding_active,
    output wire        receive_clock,
    output wire [9:0]  receive_bus_bits
);
    reg         rst_s1_reg;
    reg         rst_s2_reg;
    reg  [13:0] pin_s1_reg;
    reg  [13:0] pin_s2_reg;
    reg         tclk_prev_reg;
    reg         coding_reg;
    reg  [2:0]  rx_cnt_reg;
    reg         rx_clk_reg;
    reg  [9:0]  rx_bus_reg;
    wire        rst_n_int;
    wire        coding_pin;
    wire        vde_pin;
    wire        nib_pin;
    wire        tclk_pin;
    wire [9:0]  td_pin;
    wire        tx_rise;
    wire        tx_fall;
    wire [19:0] rx_hold_flat;

    assign rst_n_int  = rst_s2_reg;
    assign coding_pin = pin_s2_reg[13];
    assign vde_pin    = pin_s2_reg[12];
    assign nib_pin    = pin_s2_reg[11];
    assign tclk_pin   = pin_s2_reg[10];
    assign td_pin     = pin_s2_reg[9:0];
    assign tx_rise    = tclk_pin & ~tclk_prev_reg;
    assign tx_fall    = ~tclk_pin & tclk_prev_reg;
    assign coding_active    = coding_reg;
    assign receive_clock    = rx_clk_reg;
    assign receive_bus_bits = rx_bus_reg;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else if (ce) begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Every pin, the transmit clock included, passes two flip-flops.
    always @(posedge clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
            pin_s1_reg    <= 14'h0000;
            pin_s2_reg    <= 14'h0000;
            tclk_prev_reg <= 1'b0;
            coding_reg    <= 1'b0;
        end else if (ce) begin
            pin_s1_reg    <= {coding_select, violation_display_enable,
                              nibble_mode, transmit_clock,
                              transmit_bus_bits};
            pin_s2_reg    <= pin_s1_reg;
            tclk_prev_reg <= tclk_pin;
            coding_reg    <= coding_pin | coding_enable_reg_bit;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            reg  [4:0] lo_hold_reg;
            reg  [9:0] cap_reg;
            reg        cap_new_reg;
            reg  [9:0] pend_reg;
            reg        pend_full_reg;
            reg  [9:0] shift_reg;
            reg  [2:0] step_reg;
            reg        tx_rd_reg;
            reg        ovr_reg;
            reg  [9:0] rx_hold_reg;
            reg        rx_rd_reg;
            wire [9:0] enc_code;
            wire       enc_rd;
            wire [7:0] dec_data;
            wire       dec_k;
            wire       dec_cv;
            wire       dec_de;
            wire       dec_rd;
            wire       my_edge;
            wire       loading;
            wire [9:0] rx_in;

            assign my_edge = (g == 1) ? tx_rise : tx_fall;
            assign loading = pend_full_reg && (step_reg <= 3'h1);
            assign rx_in   = rx_word[10*g +: 10];
            assign ser_bits[2*g +: 2] = shift_reg[1:0];
            assign ser_valid[g]       = (step_reg != 3'h0);
            assign tx_overrun[g]      = ovr_reg;
            assign rx_hold_flat[10*g +: 10] = rx_hold_reg;

            pgc_enc u_enc (
                .data   (cap_reg[7:0]),
                .k      (cap_reg[`PGC_KFLAG_BIT]),
                .rd_in  (tx_rd_reg),
                .code   (enc_code),
                .rd_out (enc_rd)
            );

            pgc_dec u_dec (
                .code     (rx_in),
                .rd_in    (rx_rd_reg),
                .data     (dec_data),
                .k        (dec_k),
                .code_err (dec_cv),
                .disp_err (dec_de),
                .rd_out   (dec_rd)
            );

            // Capture from the DDR bus on the edges of the transmit clock.
            always @(posedge clk_sys or negedge rst_n_int) begin
                if (!rst_n_int) begin
                    lo_hold_reg <= 5'h00;
                    cap_reg     <= 10'h000;
                    cap_new_reg <= 1'b0;
                end else if (ce) begin
                    cap_new_reg <= 1'b0;
                    if (nib_pin) begin
                        if (tx_rise) begin
                            lo_hold_reg <= td_pin[5*g +: 5];
                        end
                        if (tx_fall) begin
                            cap_reg     <= {td_pin[5*g +: 5],
                                            lo_hold_reg};
                            cap_new_reg <= 1'b1;
                        end
                    end else if (my_edge) begin
                        cap_reg     <= td_pin;
                        cap_new_reg <= 1'b1;
                    end
                end
            end

            // Retimed words are coded into the holding stage, then shifted.
            always @(posedge clk_sys or negedge rst_n_int) begin
                if (!rst_n_int) begin
                    pend_reg      <= 10'h000;
                    pend_full_reg <= 1'b0;
                    shift_reg     <= 10'h000;
                    step_reg      <= 3'h0;
                    tx_rd_reg     <= 1'b0;
                    ovr_reg       <= 1'b0;
                end else if (ce) begin
                    ovr_reg <= 1'b0;
                    if (loading) begin
                        shift_reg     <= pend_reg;
                        step_reg      <= `PGC_SER_STEPS;
                        pend_full_reg <= 1'b0;
                    end else if (step_reg != 3'h0) begin
                        shift_reg <= {2'b00, shift_reg[9:2]};
                        step_reg  <= step_reg - 3'h1;
                    end
                    if (cap_new_reg) begin
                        if (coding_reg) begin
                            pend_reg  <= enc_code;
                            tx_rd_reg <= enc_rd;
                        end else begin
                            pend_reg  <= cap_reg;
                        end
                        pend_full_reg <= 1'b1;
                        ovr_reg <= pend_full_reg && !loading;
                    end
                end
            end

            // Received words are decoded and held for the output bus.
            always @(posedge clk_sys or negedge rst_n_int) begin
                if (!rst_n_int) begin
                    rx_hold_reg <= 10'h000;
                    rx_rd_reg   <= 1'b0;
                end else if (ce && rx_word_valid[g]) begin
                    if (!coding_reg) begin
                        rx_hold_reg <= rx_in;
                    end else begin
                        rx_rd_reg <= dec_rd;
                        if (vde_pin && (dec_cv || dec_de)) begin
                            rx_hold_reg <= `PGC_CV_WIDE;
                        end else if (!vde_pin && dec_cv) begin
                            rx_hold_reg <= `PGC_CV_NARROW;
                        end else begin
                            rx_hold_reg <= {1'b0, dec_k,
                                            dec_data};
                        end
                    end
                end
            end
        end
    endgenerate

    // The receive clock is divided down; data moves midway between edges.
    always @(posedge clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
            rx_cnt_reg <= 3'h0;
            rx_clk_reg <= 1'b0;
            rx_bus_reg <= 10'h000;
        end else if (ce) begin
            if (rx_cnt_reg == `PGC_RXCLK_HALF_CYC - 1) begin
                rx_cnt_reg <= 3'h0;
                rx_clk_reg <= ~rx_clk_reg;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
            end
            if (rx_cnt_reg == 3'h1) begin
                if (nib_pin) begin
                    if (!rx_clk_reg) begin
                        rx_bus_reg <= {rx_hold_flat[14:10],
                                       rx_hold_flat[4:0]};
                    end else begin
                        rx_bus_reg <= {rx_hold_flat[19:15],
                                       rx_hold_flat[9:5]};
                    end
                end else if (!rx_clk_reg) begin
                    rx_bus_reg <= rx_hold_flat[19:10];
                end else begin
                    rx_bus_reg <= rx_hold_flat[9:0];
                end
            end
        end
    end
endmodule // pgc_path

/* File: core/pgc_consts.vh */
// Constants shared by the parallel coding path: code tables and timing.
`ifndef PGC_CONSTS_VH
`define PGC_CONSTS_VH
// Six-bit sub-block codes for x = 31 down to 0, negative form, a in MSB.
`define PGC_TBL6 {6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, \
    6'h33, 6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b, \
    6'h17, 6'h1c, 6'h2c, 6'h0d, 6'h34, 6'h15, 6'h25, 6'h39, 6'h38, \
    6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27}
`define PGC_K28_6      6'h0f
`define PGC_K28_6_POS  6'h30
`define PGC_D7_6_NEG   6'h38
`define PGC_D7_6_POS   6'h07
// Four-bit sub-block codes for y = 7 down to 0, negative form, f in MSB.
`define PGC_TBL4 {4'he, 4'h6, 4'ha, 4'hd, 4'hc, 4'h5, 4'h9, 4'hb}
`define PGC_ALT7_NEG   4'h7
`define PGC_ALT7_POS   4'h8
`define PGC_Y3_NEG     4'hc
`define PGC_Y3_POS     4'h3
`define PGC_KFLAG_BIT  8
`define PGC_CV_WIDE    10'h1ff
`define PGC_CV_NARROW  10'h0ff
`define PGC_SER_STEPS  3'h5
`define PGC_SYS_PERIOD_NS 50
`define PGC_RXCLK_HALF_NS 200
`define PGC_RXCLK_HALF_CYC (`PGC_RXCLK_HALF_NS / `PGC_SYS_PERIOD_NS)
`endif

/* File: core/pgc_enc.v */
// Combinational 8b/10b encoder with running disparity in and out.
`timescale 1ns/1ps
`include "pgc_consts.vh"
module pgc_enc (
    input  wire [7:0] data,
    input  wire       k,
    input  wire       rd_in,
    output reg  [9:0] code,
    output reg        rd_out
);
    wire [191:0] tbl6 = `PGC_TBL6;
    wire [31:0]  tbl4 = `PGC_TBL4;
    reg  [5:0]   c6;
    reg  [3:0]   c4;
    reg  [2:0]   n6;
    reg  [2:0]   n4;
    reg          k28;
    reg          rd1;
    reg          alt7;
    integer      i;

    always @* begin
        k28 = k && (data[4:0] == 5'h1c);
        c6 = k28 ? `PGC_K28_6 : tbl6[6*data[4:0] +: 6];
        n6 = 3'h0;
        for (i = 0; i < 6; i = i + 1) begin
            n6 = n6 + {2'b00, c6[i]};
        end
        // The form of each sub-block keeps the line balanced.
        if (rd_in && (n6 != 3'h3 || c6 == `PGC_D7_6_NEG)) begin
            c6 = ~c6;
        end
        rd1 = (n6 == 3'h3) ? rd_in : ~rd_in;
        alt7 = (data[7:5] == 3'h7) && (k ||
            (!rd1 && (data[4:0] == 5'h11 || data[4:0] == 5'h12 ||
                      data[4:0] == 5'h14)) ||
            (rd1 && (data[4:0] == 5'h0b || data[4:0] == 5'h0d ||
                     data[4:0] == 5'h0e)));
        c4 = alt7 ? `PGC_ALT7_NEG : tbl4[4*data[7:5] +: 4];
        n4 = 3'h0;
        for (i = 0; i < 4; i = i + 1) begin
            n4 = n4 + {2'b00, c4[i]};
        end
        if ((rd1 && (n4 != 3'h2 || data[7:5] == 3'h3)) ||
            (k28 && !rd1 && n4 == 3'h2 && data[7:5] != 3'h3)) begin
            c4 = ~c4;
        end
        rd_out = (n4 == 3'h2) ? rd1 : ~rd1;
        code = {c4[0], c4[1], c4[2], c4[3],
                c6[0], c6[1], c6[2], c6[3], c6[4], c6[5]};
    end
endmodule // pgc_enc

/* File: core/pgc_dec.v */
// Combinational 8b/10b decoder with code and disparity checks.
`timescale 1ns/1ps
`include "pgc_consts.vh"
module pgc_dec (
    input  wire [9:0] code,
    input  wire       rd_in,
    output reg  [7:0] data,
    output reg        k,
    output reg        code_err,
    output reg        disp_err,
    output reg        rd_out
);
    wire [191:0] tbl6 = `PGC_TBL6;
    wire [31:0]  tbl4 = `PGC_TBL4;
    reg  [5:0]   c6;
    reg  [3:0]   c4;
    reg  [3:0]   c4x;
    reg  [5:0]   t6;
    reg  [3:0]   t4;
    reg  [2:0]   n6;
    reg  [2:0]   n4;
    reg  [2:0]   nt;
    reg          k28;
    reg          alt7;
    reg          hit6;
    reg          hit4;
    reg          pol;
    reg          dir;
    reg          rd1;
    integer      i;
    integer      j;

    always @* begin
        c6 = {code[0], code[1], code[2], code[3], code[4], code[5]};
        c4 = {code[6], code[7], code[8], code[9]};
        n6 = 3'h0;
        n4 = 3'h0;
        for (i = 0; i < 6; i = i + 1) begin
            n6 = n6 + {2'b00, c6[i]};
        end
        for (i = 0; i < 4; i = i + 1) begin
            n4 = n4 + {2'b00, c4[i]};
        end
        data = 8'h00;
        hit6 = 1'b0;
        hit4 = 1'b0;
        alt7 = 1'b0;
        k28 = (c6 == `PGC_K28_6) || (c6 == `PGC_K28_6_POS);
        if (k28) begin
            data[4:0] = 5'h1c;
            hit6 = 1'b1;
        end
        for (i = 0; i < 32; i = i + 1) begin
            t6 = tbl6[6*i +: 6];
            nt = 3'h0;
            for (j = 0; j < 6; j = j + 1) begin
                nt = nt + {2'b00, t6[j]};
            end
            if (c6 == t6 || (c6 == ~t6 && (nt != 3'h3 || i == 7))) begin
                data[4:0] = i[4:0];
                hit6 = 1'b1;
            end
        end
        c4x = (c6 == `PGC_K28_6_POS) ? ~c4 : c4;
        for (i = 0; i < 8; i = i + 1) begin
            t4 = tbl4[4*i +: 4];
            if (c4x == t4 || (c4x == ~t4 && (t4 != 4'h5 && t4 != 4'h9 &&
                t4 != 4'ha && t4 != 4'h6))) begin
                data[7:5] = i[2:0];
                hit4 = 1'b1;
            end
        end
        if (c4 == `PGC_ALT7_NEG || c4 == `PGC_ALT7_POS) begin
            data[7:5] = 3'h7;
            alt7 = 1'b1;
            hit4 = 1'b1;
        end
        k = k28 || (alt7 && (data[4:0] == 5'h17 || data[4:0] == 5'h1b ||
            data[4:0] == 5'h1d || data[4:0] == 5'h1e));
        code_err = !hit6 || !hit4 || n6 < 3'h2 || n6 > 3'h4 ||
                   n4 < 3'h1 || n4 > 3'h3;
        // Each polar sub-block must start from the disparity it expects.
        pol = n6 != 3'h3 || c6 == `PGC_D7_6_NEG || c6 == `PGC_D7_6_POS;
        dir = n6 > 3'h3 || c6 == `PGC_D7_6_POS;
        disp_err = pol && ((n6 != 3'h3) ? (rd_in == dir) : (rd_in != dir));
        rd1 = pol ? dir : rd_in;
        pol = n4 != 3'h2 || c4 == `PGC_Y3_NEG || c4 == `PGC_Y3_POS;
        dir = n4 > 3'h2 || c4 == `PGC_Y3_POS;
        disp_err = disp_err ||
            (pol && ((n4 != 3'h2) ? (rd1 == dir) : (rd1 != dir)));
        rd_out = pol ? dir : rd1;
    end
endmodule // pgc_dec

/* File: sim/pgc_path_properties.sv */
// Checker of the port behaviour of the coding path.
`timescale 1ns/1ps
module pgc_path_properties (
    input wire        clk_sys,
    input wire        rstn,
    input wire        coding_select,
    input wire        coding_enable_reg_bit,
    input wire        violation_display_enable,
    input wire        nibble_mode,
    input wire        transmit_clock,
    input wire [19:0] rx_word,
    input wire [1:0]  rx_word_valid,
    input wire [1:0]  ser_valid,
    input wire [1:0]  tx_overrun,
    input wire        coding_active,
    input wire        receive_clock,
    input wire [9:0]  receive_bus_bits
);
    reg  [2:0] cnt_reg;
    wire       bad_in;
    assign bad_in = rx_word_valid == 2'h3 && rx_word == 20'h0_0000;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            cnt_reg <= 3'h0;
        else if (cnt_reg != 3'h7)
            cnt_reg <= cnt_reg + 3'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_shown(sig);
        sig [*5];
    endsequence
    sequence s_half_high;
        receive_clock [*4] ##1 !receive_clock;
    endsequence
    property p_coding_or;
        cnt_reg == 3'h7 |-> coding_active ==
            ($past(coding_select, 3) | $past(coding_enable_reg_bit));
    endproperty
    property p_word0;
        $rose(ser_valid[0]) |-> s_shown(ser_valid[0]);
    endproperty
    property p_word1;
        $rose(ser_valid[1]) |-> s_shown(ser_valid[1]);
    endproperty
    property p_fall_word;
        $fell(transmit_clock) |-> ##[5:8] ser_valid[0];
    endproperty
    property p_rise_word;
        $rose(transmit_clock) && !nibble_mode |-> ##[5:8] ser_valid[1];
    endproperty
    property p_ovr_pulse;
        tx_overrun[1] |=> !tx_overrun[1];
    endproperty
    property p_rx_clock;
        $rose(receive_clock) |-> s_half_high;
    endproperty
    property p_bus_centred;
        $changed(receive_bus_bits) |-> ##2 $changed(receive_clock);
    endproperty
    property p_cv_wide;
        bad_in && coding_active && violation_display_enable
            |-> ##[2:12] receive_bus_bits == 10'h1ff;
    endproperty
    property p_cv_narrow;
        bad_in && coding_active && !violation_display_enable
            |-> ##[2:12] receive_bus_bits == 10'h0ff;
    endproperty
    a_coding_or: assert property (p_coding_or)
        else $error("coding enable is not the OR of its sources");
    a_word0: assert property (p_word0)
        else $error("channel 0 word not shown for five steps");
    a_word1: assert property (p_word1)
        else $error("channel 1 word not shown for five steps");
    a_fall_word: assert property (p_fall_word)
        else $error("falling transmit edge gave no channel 0 word");
    a_rise_word: assert property (p_rise_word)
        else $error("rising transmit edge gave no channel 1 word");
    a_ovr_pulse: assert property (p_ovr_pulse)
        else $error("overrun flag longer than one cycle");
    a_rx_clock: assert property (p_rx_clock)
        else $error("receive clock high phase not four cycles");
    a_bus_centred: assert property (p_bus_centred)
        else $error("receive bus change not two cycles before edge");
    a_cv_wide: assert property (p_cv_wide)
        else $error("violation not shown on bits 8 to 0");
    a_cv_narrow: assert property (p_cv_narrow)
        else $error("violation not shown on bits 7 to 0");
endmodule // pgc_path_properties

bind pgc_path pgc_path_properties u_props (
    .clk_sys(clk_sys), .rstn(rstn), .coding_select(coding_select),
    .coding_enable_reg_bit(coding_enable_reg_bit),
    .violation_display_enable(violation_display_enable),
    .nibble_mode(nibble_mode), .transmit_clock(transmit_clock),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .ser_valid(ser_valid), .tx_overrun(tx_overrun),
    .coding_active(coding_active), .receive_clock(receive_clock),
    .receive_bus_bits(receive_bus_bits)
);

/* File: sim/pgc_mac_model.sv */
// Link partner model: drives the DDR transmit clock and bus.
`timescale 1ns/1ps
module pgc_mac_model (
    input  wire       run,
    input  wire       fast,
    input  wire [9:0] nxt_r,
    input  wire [9:0] nxt_f,
    output reg        transmit_clock,
    output reg  [9:0] transmit_bus_bits,
    output reg        ack
);
    reg  [9:0] f_hold;
    time       q;
    initial begin
        transmit_clock = 1'b0;
        transmit_bus_bits = 10'h000;
        ack = 1'b0;
        f_hold = 10'h000;
        #13;
        forever begin
            q = fast ? 50 : 100;
            if (run) begin
                transmit_bus_bits = nxt_r;
                f_hold = nxt_f;
                ack = ~ack;
                #q transmit_clock = 1'b1;
                #q transmit_bus_bits = f_hold;
                #q transmit_clock = 1'b0;
                #q;
            end else begin
                transmit_bus_bits = ~transmit_bus_bits;
                #q;
            end
        end
    end
endmodule // pgc_mac_model

/* File: sim/pgc_path_tb_top.sv */
// Self-checking bench of the coding path and its link partner.
`timescale 1ns/1ps
module pgc_path_tb_top;
    reg         clk_sys = 1'b0;
    reg         rstn = 1'b0;
    reg         sel = 1'b0;
    reg         regb = 1'b0;
    reg         de = 1'b0;
    reg         nib = 1'b0;
    reg         run = 1'b0;
    reg         fast = 1'b0;
    reg  [9:0]  nxt_r = 10'h000;
    reg  [9:0]  nxt_f = 10'h000;
    reg  [19:0] rx_word = 20'h0_0000;
    reg  [1:0]  rx_word_valid = 2'h0;
    wire        tclk, act, rclk, ack;
    wire [9:0]  tbus, rbus;
    wire [3:0]  ser_bits;
    wire [1:0]  ser_valid, tx_overrun;
    integer     seed = 32'h0000_a266;
    integer     fail_count = 0;
    integer     tests_run = 0;
    integer     kind = 0;
    integer     ovr = 0;
    reg         ack_seen = 1'b0;
    reg         chk_on = 1'b1;
    reg  [9:0]  a, b, c, eh, el;
    reg  [11:0] expq[2][$];
    reg  [9:0]  acc[2];
    integer     stp[2] = '{0, 0};
    integer     rdv[2] = '{-1, -1};
    reg         rdk[2] = '{1'b0, 1'b0};

    always #25 clk_sys = ~clk_sys;

    pgc_path dut (
        .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1),
        .coding_select(sel), .coding_enable_reg_bit(regb),
        .violation_display_enable(de), .nibble_mode(nib),
        .transmit_clock(tclk), .transmit_bus_bits(tbus),
        .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .ser_bits(ser_bits), .ser_valid(ser_valid),
        .tx_overrun(tx_overrun), .coding_active(act),
        .receive_clock(rclk), .receive_bus_bits(rbus)
    );
    pgc_mac_model mac (
        .run(run), .fast(fast), .nxt_r(nxt_r), .nxt_f(nxt_f),
        .transmit_clock(tclk), .transmit_bus_bits(tbus), .ack(ack)
    );

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    function automatic [9:0] gen;
        reg [31:0] r32;
        r32 = $random(seed);
        gen = kind == 1 ? 10'h1bc : r32[9:0];
        if (kind == 2)
            gen[9:8] = 2'h0;
    endfunction

    function automatic [9:0] pick(input int g, input [9:0] r, f);
        if (nib)
            pick = g ? {f[9:5], r[9:5]} : {f[4:0], r[4:0]};
        else
            pick = g ? r : f;
    endfunction

    task automatic put_exp(input int g);
        reg [11:0] e;
        e = {2'h0, pick(g, nxt_r, nxt_f)};
        if (kind == 2)
            e = 12'h400;
        if (kind == 1)
            e = {2'h0, rdk[g] ? 10'h283 : 10'h17c};
        if (kind == 1)
            rdk[g] = ~rdk[g];
        expq[g].push_back(e);
    endtask

    task automatic got(input int g, input [9:0] w);
        reg [11:0] e;
        check({9'h000, expq[g].size() != 0}, 10'h001);
        e = expq[g].size() != 0 ? expq[g].pop_front() : 12'h3ff;
        if (e[10]) begin
            rdv[g] = rdv[g] + 2 * ($countones(w) - 5);
            check({9'h000, rdv[g] == 1 || rdv[g] == -1}, 10'h001);
        end else
            check(w, e[9:0]);
    endtask

    always @(posedge clk_sys) begin
        ovr = ovr + (tx_overrun != 2'h0);
        for (int g = 0; g < 2; g++) begin
            if (ser_valid[g] !== 1'b1)
                stp[g] = 0;
            else begin
                acc[g][2*stp[g] +: 2] = ser_bits[2*g +: 2];
                stp[g] = stp[g] + 1;
                if (stp[g] == 5) begin
                    stp[g] = 0;
                    if (chk_on)
                        got(g, acc[g]);
                end
            end
        end
    end

    task automatic do_reset(input s, r, n, d);
        @(posedge clk_sys);
        rstn <= 1'b0;
        sel <= s;
        regb <= r;
        nib <= n;
        de <= d;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            expq[g].delete();
            rdv[g] = -1;
            rdk[g] = 1'b0;
        end
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic tx_run(input int n);
        int k;
        k = 0;
        @(posedge clk_sys);
        nxt_r <= gen();
        nxt_f <= gen();
        run <= 1'b1;
        for (int i = 0; i < 40 * n && k < n; i++) begin
            @(posedge clk_sys);
            if (ack !== ack_seen) begin
                ack_seen = ack;
                put_exp(0);
                put_exp(1);
                nxt_r <= gen();
                nxt_f <= gen();
                k++;
            end
        end
        run <= 1'b0;
        for (int i = 0; i < 60 && expq[0].size() + expq[1].size(); i++)
            @(posedge clk_sys);
        check(k[9:0], n[9:0]);
        check(10'(expq[0].size() + expq[1].size()), 10'h000);
    endtask

    task automatic wait_rc(input logic v);
        logic was;
        was = rclk;
        for (int n = 0; n < 30; n++) begin
            @(posedge clk_sys);
            #1;
            if (rclk === v && was !== v)
                return;
            was = rclk;
        end
        fail_count = fail_count + 1;
        wrap_up();
    endtask

    task automatic rx_chk(input [9:0] w0, w1, ehi, elo);
        @(posedge clk_sys);
        rx_word <= {w1, w0};
        rx_word_valid <= 2'h3;
        @(posedge clk_sys);
        rx_word_valid <= 2'h0;
        wait_rc(1'b0);
        wait_rc(1'b1);
        check(rbus, ehi);
        wait_rc(1'b0);
        check(rbus, elo);
    endtask

    initial begin
        #3000000;
        fail_count = fail_count + 1;
        wrap_up();
    end

    initial begin
        for (int m = 0; m < 2; m++) begin
            do_reset(1'b0, 1'b0, m[0], 1'b1);
            check({9'h000, act}, 10'h000);
            kind = 0;
            tx_run(6);
            for (int i = 0; i < 4; i++) begin
                a = gen();
                b = gen();
                eh = m ? {b[4:0], a[4:0]} : b;
                el = m ? {b[9:5], a[9:5]} : a;
                rx_chk(a, b, eh, el);
            end
            $display("raw test %0d finished", m);
        end
        do_reset(1'b0, 1'b1, 1'b0, 1'b1);
        check({9'h000, act}, 10'h001);
        kind = 1;
        tx_run(4);
        rx_chk(10'h17c, 10'h17c, 10'h1bc, 10'h1bc);
        rx_chk(10'h155, 10'h155, 10'h0b5, 10'h0b5);
        do_reset(1'b1, 1'b0, 1'b0, 1'b1);
        check({9'h000, act}, 10'h001);
        kind = 2;
        tx_run(8);
        $display("coding tests finished");
        for (int i = 0; i < 4; i++) begin
            do_reset(1'b1, 1'b0, 1'b0, i[1]);
            c = i[0] ? 10'h283 : 10'h000;
            eh = i[1] ? 10'h1ff : (i[0] ? 10'h1bc : 10'h0ff);
            rx_chk(c, c, eh, eh);
        end
        $display("violation tests finished");
        do_reset(1'b0, 1'b0, 1'b0, 1'b0);
        chk_on = 1'b0;
        ovr = 0;
        fast <= 1'b1;
        run <= 1'b1;
        repeat (40) @(posedge clk_sys);
        run <= 1'b0;
        repeat (20) @(posedge clk_sys);
        fast <= 1'b0;
        check({9'h000, ovr != 0}, 10'h001);
        chk_on = 1'b1;
        do_reset(1'b0, 1'b0, 1'b0, 1'b0);
        $display("overrun test finished");
        wrap_up();
    end
endmodule // pgc_path_tb_top
